/* File: src/lsp_params.svh */
// Constants of the lamp switch PWM clock and supervision block.
// Assumes a 125 MHz core clock; included by the design file only.
`ifndef LSP_PARAMS_SVH
`define LSP_PARAMS_SVH

// Core clock rate
`define LSP_CLK_MHZ 125
// Serial word layout
`define LSP_WORD_W 16
`define LSP_ADDR_HI 15
`define LSP_ADDR_LO 12
`define LSP_ADDR_PWM 4'h1
`define LSP_FULL_ON_BIT 10
`define LSP_EN_BIT 9
`define LSP_SEL_BIT 8
`define LSP_DUTY_HI 7
`define LSP_DUTY_LO 0
// Status word: bit 15..12 fixed, bit 11 zero, 3 flags, phase
`define LSP_STAT_TAG 4'hA
// Times as printed
`define LSP_CS_MIN_NS 20000
`define LSP_CS_MAX_NS 200000
`define LSP_FAIL_LOW_HZ 2000
`define LSP_FAIL_HIGH_HZ 200000
`define LSP_TOGGLE_MS 250
`define LSP_DEF_PWM_HZ 120
`define LSP_PWM_STEPS 256
// Cycle counts; least times round up, longest round down
`define LSP_CS_MIN_CYC ((`LSP_CS_MIN_NS * `LSP_CLK_MHZ + 999) / 1000)
`define LSP_CS_MAX_CYC ((`LSP_CS_MAX_NS * `LSP_CLK_MHZ) / 1000)
`define LSP_FAIL_LOW_CYC ((`LSP_CLK_MHZ * 1000000) / `LSP_FAIL_LOW_HZ)
`define LSP_FAIL_HIGH_CYC ((`LSP_CLK_MHZ * 1000000) / `LSP_FAIL_HIGH_HZ)
`define LSP_TOGGLE_CYC (`LSP_TOGGLE_MS * `LSP_CLK_MHZ * 1000)
`define LSP_DEF_STEP_CYC \
  ((`LSP_CLK_MHZ * 1000000) / (`LSP_DEF_PWM_HZ * `LSP_PWM_STEPS))

`endif

/* File: src/lsp_pkg.sv */
// Types of the lamp switch PWM clock and supervision block.
// Used by the design file through scoped names only.
package lsp_pkg;
  // Calibration pulse measurement, Gray coded along idle-meas-long
  typedef enum logic [1:0] {
    LSP_CAL_IDLE = 2'b00,
    LSP_CAL_MEAS = 2'b01,
    LSP_CAL_LONG = 2'b11
  } lsp_cal_state_type;
endpackage : lsp_pkg

/* File: src/lsp_timing.sv */
// PWM clock source, calibration, clock-fail and input timeout logic.
// Assumes a host on the serial link with its own clock and chip select;
// cs_n high resets the link-side bit counter.
//
// Overview of operation
// - Flag low-frequency clock fail below a 1 to 4 kHz threshold.
// - Flag high-frequency clock fail above a 100 to 400 kHz threshold.
// - Clock-fail detection only when PWM enabled and external source chosen.
// - Uncalibrated internal PWM runs near 120 Hz, within 84 to 156 Hz.
// - Calibrated internal PWM frequency accurate within plus or minus 10 %.
// - Chip-select low pulses shorter than about 20 us do not calibrate.
// - Chip-select low pulses longer than about 200 us do not calibrate.
// - Duty supports full-on 100 % and full-off 0 %.
// - Direct-input toggle timeout of about 250 ms.
// - Chip-select rising edge moves the shifted word to its register.
// - Input sampled on falling serial clock, output changed on rising.
`timescale 1ns/100ps
`include "lsp_params.svh"
module lsp_timing #(
  parameter int CS_MAX_CYC = `LSP_CS_MAX_CYC,
  parameter int FAIL_LOW_CYC = `LSP_FAIL_LOW_CYC,
  parameter int TOGGLE_CYC = `LSP_TOGGLE_CYC
) (
  // Core clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // Direct inputs; the first carries the external PWM reference
  input wire logic pwm_ref_clock_input,
  input wire logic [2:0] direct_in,
  // Results
  output logic pwm_out,
  output logic fail_low,
  output logic fail_high,
  output logic in_timeout
);
  localparam int CS_MIN_CYC = `LSP_CS_MIN_CYC;
  localparam int FAIL_HIGH_CYC = `LSP_FAIL_HIGH_CYC;
  // Link domain: shift in on falling edge, out on rising edge
  logic [15:0] shift_q;
  logic [3:0] ocnt_q;
  logic so_q;
  logic [15:0] snap_q;
  wire link_rst_n = arst_n & ~cs_n;

  always_ff @(negedge sclk or negedge arst_n) begin
    if (!arst_n) shift_q <= 16'h0000;
    else shift_q <= {shift_q[14:0], si};
  end

  // launch on rising; counter cleared while deselected
  always_ff @(posedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      ocnt_q <= 4'h0;
      so_q <= 1'b0;
    end else begin
      ocnt_q <= ocnt_q + 4'h1;
      so_q <= snap_q[4'hF - ocnt_q];
    end
  end
  assign so = so_q;
  // Pin synchronisers; si is link-side only, so it stays out of here
  logic [4:0] sync1_q, sync2_q, prev_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= 5'h01;
      sync2_q <= 5'h01;
      prev_q <= 5'h01;
    end else begin
      sync1_q <= {direct_in, pwm_ref_clock_input, cs_n};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end
  wire cs_s = sync2_q[0];
  wire cs_rise = cs_s & ~prev_q[0];
  wire cs_fall = ~cs_s & prev_q[0];
  wire ref_rise = sync2_q[1] & ~prev_q[1];
  wire any_toggle = |(sync2_q[4:1] ^ prev_q[4:1]);

  // Control register
  logic pwm_en_q, clock_sel_q, full_on_q;
  logic [7:0] duty_q;
  wire addr_hit =
    shift_q[`LSP_ADDR_HI:`LSP_ADDR_LO] == `LSP_ADDR_PWM;

  // load on cs rise; shift_q is idle once cs is high
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pwm_en_q <= 1'b0;
      clock_sel_q <= 1'b1;
      full_on_q <= 1'b0;
      duty_q <= 8'h00;
    end else if (cs_rise && addr_hit) begin
      pwm_en_q <= shift_q[`LSP_EN_BIT];
      clock_sel_q <= shift_q[`LSP_SEL_BIT];
      full_on_q <= shift_q[`LSP_FULL_ON_BIT];
      duty_q <= shift_q[`LSP_DUTY_HI:`LSP_DUTY_LO];
    end
  end

  // Calibration of the internal step length by cs low width
  lsp_pkg::lsp_cal_state_type cal_q, cal_d;
  logic [15:0] wid_q;
  logic [14:0] step_len_q;
  wire wid_sat = wid_q >= 16'(CS_MAX_CYC + 1);
  wire in_window = (wid_q >= 16'(CS_MIN_CYC)) && !wid_sat;
  wire cal_take = cs_rise && (cal_q == lsp_pkg::LSP_CAL_MEAS) && in_window;
  always_comb begin
    cal_d = cal_q;
    case (cal_q)
      lsp_pkg::LSP_CAL_IDLE: if (cs_fall) cal_d = lsp_pkg::LSP_CAL_MEAS;
      lsp_pkg::LSP_CAL_MEAS: begin
        if (cs_rise) cal_d = lsp_pkg::LSP_CAL_IDLE;
        else if (wid_sat) cal_d = lsp_pkg::LSP_CAL_LONG;
      end
      lsp_pkg::LSP_CAL_LONG: if (cs_rise) cal_d = lsp_pkg::LSP_CAL_IDLE;
      default: cal_d = lsp_pkg::LSP_CAL_IDLE;
    endcase
  end

  // step only changes on an in-window pulse
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cal_q <= lsp_pkg::LSP_CAL_IDLE;
      wid_q <= 16'h0000;
      step_len_q <= 15'(`LSP_DEF_STEP_CYC);
    end else begin
      cal_q <= cal_d;
      wid_q <= cs_fall ? 16'h0001 : (wid_sat ? wid_q : wid_q + 16'h0001);
      if (cal_take) step_len_q <= wid_q[14:0];
    end
  end

  // Reference period monitor
  logic [15:0] per_q;
  logic fail_low_q, fail_high_q;
  wire mon_on = pwm_en_q & ~clock_sel_q;
  wire per_sat = per_q >= 16'(FAIL_LOW_CYC);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      per_q <= 16'h0000;
      fail_low_q <= 1'b0;
      fail_high_q <= 1'b0;
    end else if (!mon_on) begin
      per_q <= 16'h0000;
      fail_low_q <= 1'b0;
      fail_high_q <= 1'b0;
    end else begin
      per_q <= ref_rise ? 16'h0001 : (per_sat ? per_q : per_q + 16'h0001);
      if (per_sat) fail_low_q <= 1'b1;
      else if (ref_rise) fail_low_q <= 1'b0;
      if (ref_rise) fail_high_q <= per_q < 16'(FAIL_HIGH_CYC);
    end
  end

  // PWM phase; one step per reference rising edge or per internal step
  logic [14:0] step_cnt_q;
  logic [7:0] phase_q;
  logic pwm_q;
  // internal step from default or calibrated length
  wire int_tick = step_cnt_q >= step_len_q - 15'h0001;
  wire tick = clock_sel_q ? int_tick : ref_rise;
  wire clk_bad = ~clock_sel_q & (fail_low_q | fail_high_q);
  // full-on wins, duty zero never turns on
  wire pwm_d = pwm_en_q & ~clk_bad & (full_on_q | (phase_q < duty_q));
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      step_cnt_q <= 15'h0000;
      phase_q <= 8'h00;
      pwm_q <= 1'b0;
    end else begin
      step_cnt_q <= int_tick ? 15'h0000 : step_cnt_q + 15'h0001;
      if (tick) phase_q <= phase_q + 8'h01;
      pwm_q <= pwm_d;
    end
  end

  logic [24:0] idle_q;
  logic timeout_q;
  wire idle_end = idle_q >= 25'(TOGGLE_CYC - 1);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      idle_q <= 25'h0000000;
      timeout_q <= 1'b0;
    end else if (any_toggle) begin
      idle_q <= 25'h0000000;
      timeout_q <= 1'b0;
    end else begin
      idle_q <= idle_end ? idle_q : idle_q + 25'h0000001;
      if (idle_end) timeout_q <= 1'b1;
    end
  end

  // Status snapshot on cs fall; static while the frame shifts out
  logic so_oe_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      snap_q <= 16'h0000;
      so_oe_q <= 1'b0;
    end else begin
      if (cs_fall)
        snap_q <= {`LSP_STAT_TAG, 1'b0, fail_low_q, fail_high_q,
                   timeout_q, 8'(phase_q)};
      so_oe_q <= ~cs_s;
    end
  end
  assign so_oe = so_oe_q;
  assign pwm_out = pwm_q;
  assign fail_low = fail_low_q;
  assign fail_high = fail_high_q;
  assign in_timeout = timeout_q;
  // Checks
  sequence s_short_pulse;
    cs_rise && (cal_q == lsp_pkg::LSP_CAL_MEAS) &&
      (wid_q < 16'(CS_MIN_CYC));
  endsequence
  sequence s_long_pulse;
    cs_rise && (cal_q == lsp_pkg::LSP_CAL_LONG);
  endsequence
  property p_short_keep;
    @(posedge clock) disable iff (!arst_n)
      s_short_pulse |=> $stable(step_len_q);
  endproperty
  a_short_keep: assert property (p_short_keep)
    else $error("short cs pulse changed calibration");
  property p_long_keep;
    @(posedge clock) disable iff (!arst_n)
      s_long_pulse |=> $stable(step_len_q);
  endproperty
  a_long_keep: assert property (p_long_keep)
    else $error("long cs pulse changed calibration");
  property p_cal_only_window;
    @(posedge clock) disable iff (!arst_n)
      $changed(step_len_q) |-> $past(cal_take);
  endproperty
  a_cal_only_window: assert property (p_cal_only_window)
    else $error("calibration changed without valid pulse");
  property p_mon_off;
    @(posedge clock) disable iff (!arst_n)
      !mon_on |=> !fail_low_q && !fail_high_q;
  endproperty
  a_mon_off: assert property (p_mon_off)
    else $error("clock fail flagged while monitor off");
  property p_low_fail;
    @(posedge clock) disable iff (!arst_n)
      mon_on && per_sat |=> fail_low_q || !mon_on;
  endproperty
  a_low_fail: assert property (p_low_fail)
    else $error("missing low frequency fail");
  property p_high_fail;
    @(posedge clock) disable iff (!arst_n)
      mon_on && ref_rise && per_q < 16'(FAIL_HIGH_CYC) |=>
        fail_high_q || !mon_on;
  endproperty
  a_high_fail: assert property (p_high_fail)
    else $error("missing high frequency fail");
  property p_full_on;
    @(posedge clock) disable iff (!arst_n)
      pwm_en_q && full_on_q && !clk_bad |=> pwm_q;
  endproperty
  a_full_on: assert property (p_full_on)
    else $error("full-on duty not high");
  property p_full_off;
    @(posedge clock) disable iff (!arst_n)
      duty_q == 8'h00 && !full_on_q |=> !pwm_q;
  endproperty
  a_full_off: assert property (p_full_off)
    else $error("zero duty not low");
  property p_load;
    @(posedge clock) disable iff (!arst_n)
      cs_rise && addr_hit |=> duty_q == $past(shift_q[7:0]);
  endproperty
  a_load: assert property (p_load)
    else $error("word not loaded on cs rise");
  property p_timeout;
    @(posedge clock) disable iff (!arst_n)
      any_toggle |=> !timeout_q;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("timeout not cleared by toggle");
endmodule : lsp_timing

/* File: bench/lsp_host.sv */
// Host model: drives the serial link and the external PWM reference.
// Assumes the block samples si on falling sclk and moves so on rising.
`timescale 1ns/100ps
module lsp_host (
  // Serial link
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so,
  // External reference on the first direct input
  output logic pwm_ref_clock_input
);
  // Idle levels: link clock still, deselected
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    pwm_ref_clock_input = 1'b0;
  end

  // framing and edges
  // 160 ns link clock; si moves mid-low so both edges see it settled
  task automatic frame(input logic [15:0] w, output logic [15:0] st);
    // Step off any core clock edge the caller stands on
    #3 cs_n = 1'b0;
    #480;
    for (int i = 15; i >= 0; i--) begin
      si = w[i];
      #40 sclk = 1'b1;
      #80 sclk = 1'b0;
      st[i] = so;
      #40;
    end
    #60 cs_n = 1'b1;
    // Released line falls to its pull-down level
    si = 1'b0;
    #400;
  endtask : frame

  // Plain chip-select low pulse, link clock left still
  task automatic cs_pulse(input int ns);
    #3 cs_n = 1'b0;
    #(ns);
    cs_n = 1'b1;
    #400;
  endtask : cs_pulse

  // reference on first input
  // Rates scale with the shortened fail limit in the bench
  task automatic ref_run(input int n, input int half_ns);
    repeat (n) begin
      #(half_ns) pwm_ref_clock_input = 1'b1;
      #(half_ns) pwm_ref_clock_input = 1'b0;
    end
  endtask : ref_run
endmodule : lsp_host

/* File: bench/tb_lamp_switch_pwm_clock_timing.sv */
// Bench for the PWM clock, calibration and supervision block.
// Assumes shortened limits; the host model owns the serial link.
`timescale 1ns/100ps
module tb_lamp_switch_pwm_clock_timing;
  localparam int CS_MAX = 5000;
  localparam int FAIL_LOW = 2000;
  localparam int TOGGLE = 500;
  logic clock, arst_n, sclk, cs_n, si, so, so_oe, ref_in;
  logic pwm_out, fail_low, fail_high, in_timeout;
  logic [2:0] direct_in;
  logic [15:0] st;
  logic [7:0] ph0;
  int n_mismatch = 0;
  int compares = 0;
  wire [2:0] flags = {in_timeout, fail_high, fail_low};

  lsp_timing #(.CS_MAX_CYC(CS_MAX), .FAIL_LOW_CYC(FAIL_LOW),
    .TOGGLE_CYC(TOGGLE)) i_dut (.clock(clock), .arst_n(arst_n),
    .sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
    .pwm_ref_clock_input(ref_in), .direct_in(direct_in),
    .pwm_out(pwm_out), .fail_low(fail_low), .fail_high(fail_high),
    .in_timeout(in_timeout));
  lsp_host i_host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so),
    .pwm_ref_clock_input(ref_in));

  // 125 MHz core clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic print_verdict();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  task automatic chk1(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %0b seen %0b", nm, e, g);
    end
  endtask : chk1

  task automatic chk8(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk8

  // Wait n edges, then step past the edge so outputs have settled
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : settle

  // Bounded wait for one supervision flag
  task automatic wait_flag(input int f, input int lim);
    int k;
    k = 0;
    while (flags[f] !== 1'b1) begin
      settle(1);
      k++;
      if (k > lim) begin
        chk1("flag wait", 1'b1, flags[f]);
        print_verdict();
      end
    end
  endtask : wait_flag

  function automatic logic [15:0] ctl(logic fo, logic en, logic sel,
    logic [7:0] d);
    return {4'h1, 1'b0, fo, en, sel, d};
  endfunction : ctl

  task automatic t_duty();
    int hi;
    hi = 0;
    i_host.frame(ctl(1'b1, 1'b1, 1'b1, 8'h00), st);
    chk8("status tag", 8'h0A, {4'h0, st[15:12]});
    chk8("status flags", 8'h00, {4'h0, st[11:8]});
    chk1("so_oe idle", 1'b0, so_oe);
    settle(8);
    chk1("full on", 1'b1, pwm_out);
    i_host.frame({4'h2, 12'h000}, st);
    settle(8);
    chk1("other address", 1'b1, pwm_out);
    i_host.frame(ctl(1'b0, 1'b1, 1'b1, 8'h00), st);
    repeat (300) @(posedge clock) hi += pwm_out;
    chk1("full off highs", 1'b1, hi == 0);
  endtask : t_duty

  task automatic t_fail();
    i_host.frame(ctl(1'b0, 1'b0, 1'b0, 8'h80), st);
    settle(FAIL_LOW + 200);
    chk1("fail idle", 1'b0, fail_low);
    i_host.frame(ctl(1'b0, 1'b1, 1'b0, 8'h80), st);
    wait_flag(0, FAIL_LOW + 100);
    settle(2);
    chk1("pwm in fail", 1'b0, pwm_out);
    i_host.ref_run(4, 4000);
    chk1("low clear", 1'b0, fail_low);
    chk1("high ok", 1'b0, fail_high);
    i_host.ref_run(4, 1600);
    chk1("high fail", 1'b1, fail_high);
  endtask : t_fail

  // Let the timeout set first, so the toggle has something to clear
  task automatic t_timeout();
    wait_flag(2, TOGGLE + 100);
    @(posedge clock) direct_in <= 3'h1;
    settle(8);
    chk1("toggle clear", 1'b0, in_timeout);
    settle(TOGGLE - 108);
    chk1("toggle early", 1'b0, in_timeout);
    wait_flag(2, 200);
  endtask : t_timeout

  // Phase advance over five expected steps, snapshot to snapshot
  task automatic measure(input int step);
    i_host.frame(16'h0000, st);
    ph0 = st[7:0];
    settle(5 * step - 438);
    i_host.frame(16'h0000, st);
    ph0 = st[7:0] - ph0;
    chk1("phase advance", 1'b1, ph0 >= 8'h04 && ph0 <= 8'h06);
  endtask : measure

  task automatic t_cal();
    i_host.frame(ctl(1'b0, 1'b1, 1'b1, 8'h80), st);
    measure(4069);
    i_host.cs_pulse(2600 * 8);
    measure(2600);
    // Far outside the window, so a wrong take shows in the phase count
    i_host.cs_pulse(1000 * 8);
    measure(2600);
    i_host.cs_pulse((CS_MAX + 200) * 8);
    measure(2600);
  endtask : t_cal

  // Mid-run reset held 10 us; control must fall back to defaults
  task automatic t_reset();
    @(posedge clock) arst_n <= 1'b0;
    repeat (1250) @(posedge clock);
    arst_n <= 1'b1;
    settle(8);
    chk1("rerun pwm", 1'b0, pwm_out);
    chk1("rerun timeout", 1'b0, in_timeout);
    chk1("rerun oe", 1'b0, so_oe);
    settle(300);
    chk1("rerun pwm off", 1'b0, pwm_out);
  endtask : t_reset

  // Main sequence
  initial begin
    arst_n = 1'b0;
    direct_in = 3'h0;
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    settle(8);
    chk1("reset pwm", 1'b0, pwm_out);
    chk1("reset fail", 1'b0, fail_low | fail_high);
    t_duty();
    t_fail();
    t_timeout();
    t_cal();
    t_reset();
    print_verdict();
  end
endmodule : tb_lamp_switch_pwm_clock_timing
